// ==== logic/pcg_pkg.sv ====
// constants, register map and carrier types of the peripheral clock gating block
package pcg_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int UNIT_N = 32;
    localparam int PORT_N = 8;
    localparam int IDX_W = 6;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_RUN_CFG = 12'h060;
    localparam logic [ADDR_W-1:0] OFF_RUN_UNIT = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_RUN_PORT = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_SLP_UNIT = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_SLP_PORT = 12'h118;
    localparam logic [ADDR_W-1:0] OFF_DS_UNIT = 12'h124;
    localparam logic [ADDR_W-1:0] OFF_DS_PORT = 12'h128;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h150;
    localparam logic [ADDR_W-1:0] OFF_INT_EN = 12'h154;
    localparam logic [ADDR_W-1:0] OFF_INT_CLR = 12'h158;
    localparam logic [ADDR_W-1:0] OFF_EFF_UNIT = 12'h160;
    localparam logic [ADDR_W-1:0] OFF_EFF_PORT = 12'h164;

    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    // comparators 25:24, timers 19:16, two-wire 14/12, sync serial 5:4, async serial 2:0
    localparam logic [UNIT_N-1:0] UNIT_MASK = 32'h030F_5037;
    localparam logic [PORT_N-1:0] PORT_MASK = 8'hFF;
    localparam int AUTO_GATING_BIT = 0;
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_MODE_BIT = 1;
    localparam logic [IDX_W-1:0] PORT_BASE = 6'h20;
    localparam logic [2:0] PORT_GROUP = 3'h4;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [PORT_N-1:0] RST_PORT = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCG_RUN = 2'b00,
        PCG_SLEEP = 2'b01,
        PCG_DEEP = 2'b10
    } pcg_mode_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } pcg_apb_req_s;

    // access from the system bus to one gated unit: 0..31 units, 32..39 ports
    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] unit;
    } pcg_acc_s;

endpackage

// ==== logic/pcg_clk_gate.sv ====
// glitch-free clock gate cell for one peripheral unit
`timescale 1ns/1ps
`default_nettype none
module pcg_clk_gate (
    input wire logic clk,
    input wire logic en,
    output logic gclk
);
    logic en_lat;

    // ------------------------------------------------------------------
    // gate
    // ------------------------------------------------------------------
    // enable may only change while clk is low, so no runt pulse escapes
    always_latch begin
        if (!clk) begin
            en_lat = en;
        end
    end

    assign gclk = clk & en_lat;

endmodule // pcg_clk_gate
`default_nettype wire

// ==== logic/pcg_fault_check.sv ====
// bus fault answer for accesses to peripheral units
`timescale 1ns/1ps
`default_nettype none
module pcg_fault_check (
    input wire logic clk,
    input wire logic rst,
    input wire pcg_pkg::pcg_acc_s acc,
    input wire logic [pcg_pkg::UNIT_N-1:0] unit_en,
    input wire logic [pcg_pkg::PORT_N-1:0] port_en,
    output logic fault,
    output logic ok
);
    import pcg_pkg::*;

    logic fault_r, fault_nxt, ok_r, ok_nxt, clocked;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    always_comb begin
        clocked = 1'b0;
        if (acc.unit < PORT_BASE) begin
            clocked = unit_en[acc.unit[4:0]];
        end else if (acc.unit[5:3] == PORT_GROUP) begin
            clocked = port_en[acc.unit[2:0]];
        end
        fault_nxt = acc.valid & ~clocked;
        ok_nxt = acc.valid & clocked;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_r <= 1'b0;
            ok_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            ok_r <= ok_nxt;
        end
    end

    assign fault = fault_r;
    assign ok = ok_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_gated_fault: assert property (@(posedge clk) disable iff (rst)
        acc.valid && !clocked |=> fault && !ok)
        else $error("access to gated unit not faulted");

    chk_clocked_ok: assert property (@(posedge clk) disable iff (rst)
        acc.valid && clocked |=> ok && !fault)
        else $error("access to clocked unit did not complete");

endmodule // pcg_fault_check
`default_nettype wire

// ==== logic/pcg_top.sv ====
// peripheral clock gating control: apb registers, mode sets and unit clock gates
// Function
// - enabled unit gets its clock
// - disabled unit clock stopped
// - access to gated unit gives fault
// - all enables reset to zero
// - run, sleep, deep-sleep sets held
// - sleep sets apply only with auto-gating
// - run port register, ports H..A
// - sleep port register, same layout
// - port register upper bits read zero
// - deep set: comparators and timers bits
// - deep set: serial module bits
// - deep set reserved fields read zero
// - absent unit positions read zero
// - deep unit register at its offset
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pcg_top (
    input wire logic clk,
    input wire logic rst,
    input wire pcg_pkg::pcg_apb_req_s apb_req,
    output logic pready,
    output logic [pcg_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic deepsleep_req,
    input wire pcg_pkg::pcg_acc_s acc,
    output logic acc_fault,
    output logic acc_ok,
    output logic [pcg_pkg::UNIT_N-1:0] unit_clk,
    output logic [pcg_pkg::UNIT_N-1:0] unit_clk_en,
    output logic [pcg_pkg::PORT_N-1:0] port_clk,
    output logic [pcg_pkg::PORT_N-1:0] port_clk_en,
    output pcg_pkg::pcg_mode_e mode,
    output logic irq
);
    import pcg_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [UNIT_N-1:0] run_unit_r, run_unit_nxt;
    logic [UNIT_N-1:0] slp_unit_r, slp_unit_nxt;
    logic [UNIT_N-1:0] ds_unit_r, ds_unit_nxt;
    logic [PORT_N-1:0] run_port_r, run_port_nxt;
    logic [PORT_N-1:0] slp_port_r, slp_port_nxt;
    logic [PORT_N-1:0] ds_port_r, ds_port_nxt;
    logic auto_gating_select_r, auto_gating_select_nxt;
    logic [IRQ_W-1:0] int_stat_r, int_stat_nxt;
    logic [IRQ_W-1:0] int_en_r, int_en_nxt;
    logic ack_r, ack_nxt;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;
    pcg_mode_e mode_r, mode_nxt;
    logic [UNIT_N-1:0] eff_unit_r, eff_unit_nxt;
    logic [PORT_N-1:0] eff_port_r, eff_port_nxt;

    logic acc_phase;
    logic wr_en;
    logic addr_hit;
    logic [DATA_W-1:0] rd_val;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic fault_pulse;
    logic [UNIT_N-1:0] wdata_unit;
    logic [PORT_N-1:0] wdata_port;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // every access takes two access-phase cycles: the first captures read
    // data into a flop, the second raises pready; writes land on the second
    assign acc_phase = apb_req.psel & apb_req.penable;
    assign wr_en = acc_phase & ack_r & apb_req.pwrite & addr_hit;
    // reserved and absent positions never store a one
    assign wdata_unit = apb_req.pwdata & UNIT_MASK;
    assign wdata_port = apb_req.pwdata[PORT_N-1:0] & PORT_MASK;

    always_comb begin
        rd_val = RST_WORD;
        addr_hit = 1'b1;
        case (apb_req.paddr)
            OFF_RUN_CFG: begin
                rd_val[AUTO_GATING_BIT] = auto_gating_select_r;
            end
            OFF_RUN_UNIT: begin
                rd_val = run_unit_r;
            end
            OFF_RUN_PORT: begin
                rd_val[PORT_N-1:0] = run_port_r;
            end
            OFF_SLP_UNIT: begin
                rd_val = slp_unit_r;
            end
            OFF_SLP_PORT: begin
                rd_val[PORT_N-1:0] = slp_port_r;
            end
            OFF_DS_UNIT: begin
                rd_val = ds_unit_r;
            end
            OFF_DS_PORT: begin
                rd_val[PORT_N-1:0] = ds_port_r;
            end
            OFF_INT_STAT: begin
                rd_val[IRQ_W-1:0] = int_stat_r;
            end
            OFF_INT_EN: begin
                rd_val[IRQ_W-1:0] = int_en_r;
            end
            OFF_INT_CLR: begin
                rd_val = RST_WORD;
            end
            OFF_EFF_UNIT: begin
                rd_val = eff_unit_r;
            end
            OFF_EFF_PORT: begin
                rd_val[PORT_N-1:0] = eff_port_r;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    always_comb begin
        run_unit_nxt = run_unit_r;
        slp_unit_nxt = slp_unit_r;
        ds_unit_nxt = ds_unit_r;
        run_port_nxt = run_port_r;
        slp_port_nxt = slp_port_r;
        ds_port_nxt = ds_port_r;
        auto_gating_select_nxt = auto_gating_select_r;
        int_en_nxt = int_en_r;
        irq_clear = RST_IRQ;
        ack_nxt = acc_phase & ~ack_r;
        prdata_nxt = prdata_r;
        if (acc_phase && !ack_r) begin
            prdata_nxt = rd_val;
        end
        if (wr_en) begin
            case (apb_req.paddr)
                OFF_RUN_CFG: begin
                    auto_gating_select_nxt = apb_req.pwdata[AUTO_GATING_BIT];
                end
                OFF_RUN_UNIT: begin
                    run_unit_nxt = wdata_unit;
                end
                OFF_RUN_PORT: begin
                    run_port_nxt = wdata_port;
                end
                OFF_SLP_UNIT: begin
                    slp_unit_nxt = wdata_unit;
                end
                OFF_SLP_PORT: begin
                    slp_port_nxt = wdata_port;
                end
                OFF_DS_UNIT: begin
                    ds_unit_nxt = wdata_unit;
                end
                OFF_DS_PORT: begin
                    ds_port_nxt = wdata_port;
                end
                OFF_INT_EN: begin
                    int_en_nxt = apb_req.pwdata[IRQ_W-1:0];
                end
                OFF_INT_CLR: begin
                    irq_clear = apb_req.pwdata[IRQ_W-1:0];
                end
                default: begin
                    irq_clear = RST_IRQ;
                end
            endcase
        end
        irq_events = RST_IRQ;
        irq_events[IRQ_FAULT_BIT] = fault_pulse;
        irq_events[IRQ_MODE_BIT] = (mode_nxt != mode_r);
        // a new event in the clearing cycle survives the clear
        int_stat_nxt = (int_stat_r & ~irq_clear) | irq_events;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_unit_r <= RST_WORD;
            slp_unit_r <= RST_WORD;
            ds_unit_r <= RST_WORD;
            run_port_r <= RST_PORT;
            slp_port_r <= RST_PORT;
            ds_port_r <= RST_PORT;
            auto_gating_select_r <= 1'b0;
            int_stat_r <= RST_IRQ;
            int_en_r <= RST_IRQ;
            ack_r <= 1'b0;
            prdata_r <= RST_WORD;
        end else begin
            run_unit_r <= run_unit_nxt;
            slp_unit_r <= slp_unit_nxt;
            ds_unit_r <= ds_unit_nxt;
            run_port_r <= run_port_nxt;
            slp_port_r <= slp_port_nxt;
            ds_port_r <= ds_port_nxt;
            auto_gating_select_r <= auto_gating_select_nxt;
            int_stat_r <= int_stat_nxt;
            int_en_r <= int_en_nxt;
            ack_r <= ack_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready = ack_r;
    assign prdata = prdata_r;
    assign pslverr = ack_r & acc_phase & ~addr_hit;
    assign irq = |(int_stat_r & int_en_r);

    // ------------------------------------------------------------------
    // power mode and set selection
    // ------------------------------------------------------------------
    // without auto gating the run set stays in force through every sleep
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            PCG_RUN: begin
                if (auto_gating_select_r && deepsleep_req) begin
                    mode_nxt = PCG_DEEP;
                end else if (auto_gating_select_r && sleep_req) begin
                    mode_nxt = PCG_SLEEP;
                end
            end
            PCG_SLEEP: begin
                if (!auto_gating_select_r || (!sleep_req && !deepsleep_req)) begin
                    mode_nxt = PCG_RUN;
                end else if (deepsleep_req) begin
                    mode_nxt = PCG_DEEP;
                end
            end
            PCG_DEEP: begin
                if (!auto_gating_select_r || (!sleep_req && !deepsleep_req)) begin
                    mode_nxt = PCG_RUN;
                end else if (!deepsleep_req) begin
                    mode_nxt = PCG_SLEEP;
                end
            end
            default: begin
                mode_nxt = PCG_RUN;
            end
        endcase
        case (mode_r)
            PCG_SLEEP: begin
                eff_unit_nxt = slp_unit_r;
                eff_port_nxt = slp_port_r;
            end
            PCG_DEEP: begin
                eff_unit_nxt = ds_unit_r;
                eff_port_nxt = ds_port_r;
            end
            default: begin
                eff_unit_nxt = run_unit_r;
                eff_port_nxt = run_port_r;
            end
        endcase
    end

    // enables come from flops so the gate latches never see decode hazards
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= PCG_RUN;
            eff_unit_r <= RST_WORD;
            eff_port_r <= RST_PORT;
        end else begin
            mode_r <= mode_nxt;
            eff_unit_r <= eff_unit_nxt;
            eff_port_r <= eff_port_nxt;
        end
    end

    assign unit_clk_en = eff_unit_r;
    assign port_clk_en = eff_port_r;
    assign mode = mode_r;

    // ------------------------------------------------------------------
    // clock gates and fault answer
    // ------------------------------------------------------------------
    for (genvar i = 0; i < UNIT_N; i++) begin : g_unit
        if (UNIT_MASK[i]) begin : g_present
            pcg_clk_gate u_gate (
                .clk(clk),
                .en(eff_unit_r[i]),
                .gclk(unit_clk[i])
            );
        end else begin : g_absent
            assign unit_clk[i] = 1'b0;
        end
    end

    for (genvar i = 0; i < PORT_N; i++) begin : g_port
        pcg_clk_gate u_gate (
            .clk(clk),
            .en(eff_port_r[i]),
            .gclk(port_clk[i])
        );
    end

    pcg_fault_check u_fault (
        .clk(clk),
        .rst(rst),
        .acc(acc),
        .unit_en(eff_unit_r),
        .port_en(eff_port_r),
        .fault(fault_pulse),
        .ok(acc_ok)
    );

    assign acc_fault = fault_pulse;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_run_port_write;
        wr_en && apb_req.paddr == OFF_RUN_PORT && mode_r == PCG_RUN && mode_nxt == PCG_RUN;
    endsequence

    sequence s_enter_deep;
        auto_gating_select_r && deepsleep_req && mode_r == PCG_RUN;
    endsequence

    chk_reset_zero: assert property ($past(rst) |->
        run_unit_r == RST_WORD && ds_unit_r == RST_WORD && run_port_r == RST_PORT
        && eff_unit_r == RST_WORD && eff_port_r == RST_PORT)
        else $error("enables not zero after reset");

    chk_reserved_zero: assert property (
        ((run_unit_r | slp_unit_r | ds_unit_r) & ~UNIT_MASK) == RST_WORD)
        else $error("reserved enable position holds a one");

    chk_write_applies: assert property (s_run_port_write |-> ##2
        eff_port_r == $past(wdata_port, 2))
        else $error("run port write not applied to clock enables");

    chk_run_set_used: assert property (mode_r == PCG_RUN |=>
        eff_unit_r == $past(run_unit_r) && eff_port_r == $past(run_port_r))
        else $error("run set not driving enables");

    chk_sleep_set_used: assert property (mode_r == PCG_SLEEP |=>
        eff_unit_r == $past(slp_unit_r) && eff_port_r == $past(slp_port_r))
        else $error("sleep set not driving enables");

    chk_deep_entry: assert property (s_enter_deep |=> mode_r == PCG_DEEP ##1
        eff_unit_r == $past(ds_unit_r))
        else $error("deep-sleep set not applied");

    chk_no_auto_gating: assert property (!auto_gating_select_r |=> mode_r == PCG_RUN)
        else $error("sleep set used without auto gating");

    chk_fault_sticky: assert property (fault_pulse |=> int_stat_r[IRQ_FAULT_BIT])
        else $error("fault event not recorded");

    chk_apb_ready: assert property (acc_phase && !ack_r |=> pready)
        else $error("apb access not answered in two cycles");

endmodule // pcg_top
`default_nettype wire

// ==== sim/pcg_tb.sv ====
// self-checking testbench for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcg_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] exp;
    } pcg_row_s;

    logic clk;
    logic rst;
    pcg_apb_req_s apb_req;
    logic pready;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
    logic sleep_req;
    logic deepsleep_req;
    pcg_acc_s acc;
    logic acc_fault;
    logic acc_ok;
    logic [UNIT_N-1:0] unit_clk;
    logic [UNIT_N-1:0] unit_clk_en;
    logic [PORT_N-1:0] port_clk;
    logic [PORT_N-1:0] port_clk_en;
    pcg_mode_e mode;
    logic irq;
    int n_mismatch;
    int samples_checked;
    logic [DATA_W-1:0] rdat;
    logic rerr;
    logic [PORT_N-1:0] hi;
    logic [PORT_N-1:0] lo;
    logic [UNIT_N-1:0] uhi;
    pcg_row_s rows [11];
    logic [6:0] probes [10];

    pcg_top i_pcg_top (.clk(clk), .rst(rst), .apb_req(apb_req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sleep_req(sleep_req),
        .deepsleep_req(deepsleep_req), .acc(acc), .acc_fault(acc_fault), .acc_ok(acc_ok),
        .unit_clk(unit_clk), .unit_clk_en(unit_clk_en), .port_clk(port_clk),
        .port_clk_en(port_clk_en), .mode(mode), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        // pready is a flop: seen 1 ns after an edge it is what the next edge samples
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("ERROR apb_wait expected %h seen %h", 1'b1, pready);
            tally_and_finish();
        end
        rdat = prdata;
        rerr = pslverr;
        @(posedge clk);
        apb_req <= '0;
    endtask

    task automatic rchk(input string name, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
        apb(1'b0, a, '0);
        check(name, rdat, exp);
        check({name, "_err"}, {31'b0, rerr}, 32'h0000_0000);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic probe(input logic [IDX_W-1:0] u, input logic f);
        @(posedge clk);
        acc <= '{valid: 1'b1, unit: u};
        @(posedge clk);
        acc <= '0;
        #1;
        check("acc_answer", {30'b0, acc_fault, acc_ok}, {30'b0, f, ~f});
    endtask

    // samples both clock phases so a running port clock shows high and low; unit clocks are sampled in the high phase only
    task automatic clkscan();
        hi = '0;
        lo = '0;
        uhi = '0;
        repeat (8) begin
            @(posedge clk);
            #2;
            hi |= port_clk;
            uhi |= unit_clk;
            lo |= ~port_clk;
            @(negedge clk);
            #2;
            hi |= port_clk;
            lo |= ~port_clk;
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        apb_req = '0;
        sleep_req = 1'b0;
        deepsleep_req = 1'b0;
        acc = '0;
        n_mismatch = 0;
        samples_checked = 0;
        rows = '{'{12'h104, 32'hffff_ffff, 32'h030f_5037}, '{12'h114, 32'hffff_ffff, 32'h030f_5037},
                 '{12'h124, 32'hffff_ffff, 32'h030f_5037}, '{12'h108, 32'hffff_ffff, 32'h0000_00ff},
                 '{12'h118, 32'hffff_ffff, 32'h0000_00ff}, '{12'h128, 32'hffff_ffff, 32'h0000_00ff},
                 '{12'h150, 32'hffff_ffff, 32'h0000_0000}, '{12'h158, 32'h0000_0000, 32'h0000_0000},
                 '{12'h060, 32'h0000_0000, 32'h0000_0000}, '{12'h124, 32'hfcf0_afc8, 32'h0000_0000},
                 '{12'h108, 32'hffff_ff00, 32'h0000_0000}};
        // unit index and expected fault with units 24,12,0 and ports A,C clocked
        probes = '{{6'd24, 1'b0}, {6'd25, 1'b1}, {6'd12, 1'b0}, {6'd0, 1'b0}, {6'd1, 1'b1},
                   {6'd32, 1'b0}, {6'd33, 1'b1}, {6'd34, 1'b0}, {6'd40, 1'b1}, {6'd6, 1'b1}};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        check("unit_en_rst", unit_clk_en, 32'h0000_0000);
        check("port_en_rst", {24'b0, port_clk_en}, 32'h0000_0000);
        foreach (rows[i]) rchk("reg_rst", rows[i].addr, 32'h0000_0000);
        $display("test reset values done");

        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            rchk("reg_rw", rows[i].addr, rows[i].exp);
        end
        apb(1'b0, 12'h200, '0);
        check("unmapped", {rerr, rdat[30:0]}, 32'h8000_0000);
        $display("test register layout done");

        apb(1'b1, 12'h104, 32'h0100_1001);
        apb(1'b0, 12'h108, '0);
        apb(1'b1, 12'h108, (rdat & 32'hffff_ff00) | 32'h0000_0005);
        apb(1'b1, 12'h114, 32'h0000_0010);
        apb(1'b1, 12'h118, 32'h0000_0030);
        apb(1'b1, 12'h124, 32'h0200_0000);
        apb(1'b1, 12'h128, 32'h0000_0080);
        settle(3);
        check("unit_en_run", unit_clk_en, 32'h0100_1001);
        rchk("eff_port", 12'h164, 32'h0000_0005);
        clkscan();
        check("port_clk_run", {hi, lo}, 16'h05ff);
        check("unit_clk_run", uhi, 32'h0100_1001);
        foreach (probes[i]) probe(probes[i][6:1], probes[i][0]);
        $display("test run gating and faults done");

        @(posedge clk);
        sleep_req <= 1'b1;
        settle(3);
        check("mode_no_auto", {22'b0, mode, port_clk_en}, {22'b0, PCG_RUN, 8'h05});
        apb(1'b1, 12'h060, 32'h0000_0001);
        settle(3);
        check("mode_sleep", {22'b0, mode, port_clk_en}, {22'b0, PCG_SLEEP, 8'h30});
        check("unit_sleep", unit_clk_en, 32'h0000_0010);
        @(posedge clk);
        deepsleep_req <= 1'b1;
        settle(3);
        check("mode_deep", {22'b0, mode, port_clk_en}, {22'b0, PCG_DEEP, 8'h80});
        check("unit_deep", unit_clk_en, 32'h0200_0000);
        clkscan();
        check("port_clk_deep", {hi, lo}, 16'h80ff);
        check("unit_clk_deep", uhi, 32'h0200_0000);
        probe(6'd25, 1'b0);
        probe(6'd24, 1'b1);
        @(posedge clk);
        sleep_req <= 1'b0;
        deepsleep_req <= 1'b0;
        settle(3);
        check("mode_back", {22'b0, mode, port_clk_en}, {22'b0, PCG_RUN, 8'h05});
        $display("test power modes done");

        // interrupt: raise, clear, mask
        apb(1'b1, 12'h158, 32'h0000_0003);
        apb(1'b1, 12'h154, 32'h0000_0001);
        settle(1);
        check("irq_idle", {31'b0, irq}, 32'h0000_0000);
        probe(6'd33, 1'b1);
        settle(2);
        check("irq_fault", {31'b0, irq}, 32'h0000_0001);
        rchk("status_fault", 12'h150, 32'h0000_0001);
        apb(1'b1, 12'h158, 32'h0000_0001);
        settle(1);
        check("irq_cleared", {31'b0, irq}, 32'h0000_0000);
        apb(1'b1, 12'h154, 32'h0000_0000);
        probe(6'd33, 1'b1);
        settle(2);
        check("irq_masked", {31'b0, irq}, 32'h0000_0000);
        rchk("status_masked", 12'h150, 32'h0000_0001);
        apb(1'b1, 12'h158, 32'h0000_0003);
        apb(1'b1, 12'h154, 32'h0000_0002);
        @(posedge clk);
        deepsleep_req <= 1'b1;
        settle(3);
        check("irq_mode", {29'b0, mode, irq}, {29'b0, PCG_DEEP, 1'b1});
        $display("test interrupt done");

        @(posedge clk);
        rst <= 1'b1;
        deepsleep_req <= 1'b0;
        settle(2);
        rst <= 1'b0;
        settle(1);
        check("rerst_en", {unit_clk_en[23:0], port_clk_en}, 32'h0000_0000);
        check("rerst_mode", {30'b0, mode}, {30'b0, PCG_RUN});
        check("rerst_irq", {31'b0, irq}, 32'h0000_0000);
        rchk("rerst_reg", 12'h124, 32'h0000_0000);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
